// >>> xfer_pkg.sv
package xfer_pkg;
	localparam int DATA_W = 64;
	localparam int HALF_W = 32;
	localparam int SIZE_W = 3;
	localparam int KIND_W = 5;
	localparam int BEATS_W = 3;
	// A burst is four beats; a single transfer is one.
	localparam logic [BEATS_W-1:0] BURST_BEATS = 3'h4;
	localparam logic [BEATS_W-1:0] SINGLE_BEATS = 3'h1;
	localparam logic [BEATS_W-1:0] ZERO_BEATS = 3'h0;
	localparam logic [BEATS_W-1:0] ONE_BEAT = 3'h1;
	// Transfer kinds used by this block.
	localparam logic [KIND_W-1:0] KIND_WRITE = 5'h02;
	localparam logic [KIND_W-1:0] KIND_READ = 5'h0a;
	localparam logic [KIND_W-1:0] KIND_SNOOP_BCAST = 5'h12;
	localparam logic [KIND_W-1:0] KIND_GFX_READ = 5'h16;
	localparam logic [KIND_W-1:0] KIND_GFX_WRITE = 5'h1e;
	localparam logic [SIZE_W-1:0] SIZE_DWORD = 3'h0;
	// Bit 4 of the transfer kind set marks a direct-store access.
	localparam int KIND_DSTORE_BIT = 4;
	localparam logic [KIND_W-1:0] KIND_DSTORE_MASK = 5'h10;
	localparam logic [KIND_W-1:0] KIND_DSTORE_MATCH = 5'h10;

	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_DATA = 2'b01,
		DEV_SIDE = 2'b10,
		DEV_ERR = 2'b11
	} dev_state_t;

	typedef enum logic [1:0] {
		MST_IDLE = 2'b00,
		MST_ADDR = 2'b01,
		MST_DATA = 2'b10
	} mst_state_t;

	// Unsupported kinds: graphics transfers and direct-store kinds other than the snoop broadcast.
	function automatic logic kind_unsupported(input logic [KIND_W-1:0] k);
		kind_unsupported = (k == KIND_GFX_READ) || (k == KIND_GFX_WRITE) ||
			(((k & KIND_DSTORE_MASK) == KIND_DSTORE_MATCH) && (k != KIND_SNOOP_BCAST));
	endfunction

	function automatic logic kind_is_write(input logic [KIND_W-1:0] k);
		kind_is_write = (k == KIND_WRITE) || (k == KIND_GFX_WRITE);
	endfunction
endpackage

// >>> xfer_if.sv
`timescale 1ns/100ps
interface xfer_if;
	import xfer_pkg::*;
	// Master-driven address tenure.
	logic transaction_begin;
	logic extended_start_request;
	logic [KIND_W-1:0] transfer_kind;
	logic [SIZE_W-1:0] beat_size;
	logic burst_flag;
	logic coherent_access;
	logic write_through_hint;
	logic no_cache_hint;
	// Device-driven address tenure for snoop broadcasts.
	logic dev_transaction_begin;
	logic [KIND_W-1:0] dev_transfer_kind;
	logic [SIZE_W-1:0] dev_beat_size;
	logic dev_burst_flag;
	logic dev_coherent_access;
	logic dev_write_through_hint;
	logic dev_no_cache_hint;
	logic dev_attr_oe;
	// Address tenure end and retry.
	logic address_phase_done;
	logic address_retry;
	// Data halves; high half holds byte lanes 0 to 3.
	logic [HALF_W-1:0] data_high_half_m;
	logic [HALF_W-1:0] data_low_half_m;
	logic [HALF_W-1:0] data_high_half_d;
	logic [HALF_W-1:0] data_low_half_d;
	logic data_d_oe;
	// Termination.
	logic beat_acknowledge;
	logic side_beat_acknowledge;
	logic bus_error_ack;
	logic side_slave_claim;
	logic fatal_error_out;

	modport device (
		input transaction_begin, extended_start_request, transfer_kind, beat_size, burst_flag,
		input coherent_access, write_through_hint, no_cache_hint, side_slave_claim,
		input data_high_half_m, data_low_half_m, side_beat_acknowledge, address_retry,
		output dev_transaction_begin, dev_transfer_kind, dev_beat_size, dev_burst_flag,
		output dev_coherent_access, dev_write_through_hint, dev_no_cache_hint, dev_attr_oe,
		output address_phase_done, data_high_half_d, data_low_half_d, data_d_oe,
		output beat_acknowledge, bus_error_ack, fatal_error_out
	);
	modport master (
		output transaction_begin, extended_start_request, transfer_kind, beat_size, burst_flag,
		output coherent_access, write_through_hint, no_cache_hint, side_slave_claim,
		output data_high_half_m, data_low_half_m, side_beat_acknowledge, address_retry,
		input dev_transaction_begin, dev_transfer_kind, dev_beat_size, dev_burst_flag,
		input dev_coherent_access, dev_write_through_hint, dev_no_cache_hint, dev_attr_oe,
		input address_phase_done, data_high_half_d, data_low_half_d, data_d_oe,
		input beat_acknowledge, bus_error_ack, fatal_error_out
	);
endinterface

// >>> xfer_device.sv
`timescale 1ns/100ps
// Operation
// (RULE1) Target acknowledges each data beat once.
// (RULE2) Last or only beat ends data tenure.
// (RULE3) Claiming slave drives acknowledge per beat.
// (RULE4) Claimed transactions get no device acknowledge; a claimed access that draws an error still gets the error acknowledge.
// (RULE5) Error acknowledge ends current transaction immediately.
// (RULE6) Unsupported kinds answered with error when enabled.
// (RULE7) Extended start answered with error when enabled.
// (RULE8) Device starts only snoop broadcast transactions.
// (RULE9) Master gives start with valid attributes.
// (RULE10) Catastrophic error raises machine-check output.
// (RULE11) Three-bit size field decoded on acceptance.
// (RULE12) Five-bit kind field driven and decoded.
// (RULE13) Coherent attribute marks snooped global access.
// (RULE14) Burst flag marks multi-beat transfer.
// (RULE15) Write-through and cache-inhibit travel together.
// (RULE16) Address tenure ends with phase-done acknowledge.
// (RULE17) Data bus split into two halves.
// (RULE18) Error beats never overlap normal acknowledges.
module xfer_device
	import xfer_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Link.
	xfer_if.device bus,
	// User side.
	input wire logic error_ack_enable_i,
	input wire logic fatal_error_i,
	input wire logic snoop_req_i,
	input wire logic snoop_coherent_i,
	input wire logic snoop_write_through_i,
	input wire logic snoop_no_cache_i,
	input wire logic [DATA_W-1:0] read_data_i,
	output logic snoop_busy_o,
	output logic [DATA_W-1:0] write_data_o,
	output logic write_valid_o,
	output logic [KIND_W-1:0] accepted_kind_o,
	output logic [SIZE_W-1:0] accepted_size_o,
	output logic accepted_coherent_o,
	output logic accepted_write_through_o,
	output logic accepted_no_cache_o,
	output logic tenure_done_o
);
	dev_state_t state_reg;
	logic [BEATS_W-1:0] beats_reg;
	logic write_reg;
	logic ack_reg;
	logic err_reg;
	logic address_phase_done_reg;
	logic mcp_reg;
	logic snoop_reg;
	logic done_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic wvalid_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic start_seen;
	logic bad_access;
	logic last_beat;

	////////////////////////////////////////////////////////////////////////////////
	assign start_seen = bus.transaction_begin || bus.extended_start_request; // (RULE9)
	// Errors are only reported when enabled; otherwise the access is served normally.
	assign bad_access = error_ack_enable_i &&
		(bus.extended_start_request || kind_unsupported(bus.transfer_kind)); // (RULE6) (RULE7)
	assign last_beat = (beats_reg == ONE_BEAT);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= DEV_IDLE;
			beats_reg <= ZERO_BEATS;
			write_reg <= 1'b0;
			address_phase_done_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (en_i) begin
			address_phase_done_reg <= 1'b0;
			done_reg <= 1'b0;
			unique case (state_reg)
				DEV_IDLE: begin
					if (start_seen && !snoop_reg) begin
						address_phase_done_reg <= 1'b1; // (RULE16)
						write_reg <= kind_is_write(bus.transfer_kind);
						beats_reg <= bus.burst_flag ? BURST_BEATS : SINGLE_BEATS; // (RULE14)
						if (bad_access) begin
							state_reg <= DEV_ERR;
						end else if (bus.side_slave_claim) begin
							state_reg <= DEV_SIDE; // (RULE4)
						end else begin
							state_reg <= DEV_DATA;
						end
					end
				end
				DEV_DATA: begin
					if (ack_reg) begin
						beats_reg <= beats_reg - ONE_BEAT;
						if (last_beat) begin
							state_reg <= DEV_IDLE; // (RULE2)
							done_reg <= 1'b1;
						end
					end
				end
				DEV_SIDE: begin
					if (bus.side_beat_acknowledge) begin // (RULE3)
						beats_reg <= beats_reg - ONE_BEAT;
						if (last_beat) begin
							state_reg <= DEV_IDLE;
							done_reg <= 1'b1;
						end
					end
				end
				DEV_ERR: begin
					if (err_reg) begin
						state_reg <= DEV_IDLE; // (RULE5)
						beats_reg <= ZERO_BEATS;
						done_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Acknowledges are registered: one beat per two cycles keeps read data settled.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
		end else if (en_i) begin
			ack_reg <= (state_reg == DEV_DATA) && !ack_reg && !err_reg; // (RULE1) (RULE18)
			err_reg <= (state_reg == DEV_ERR) && !err_reg; // (RULE5)
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= '0;
			wdata_reg <= '0;
			wvalid_reg <= 1'b0;
		end else if (en_i) begin
			wvalid_reg <= 1'b0;
			if (state_reg == DEV_DATA && !ack_reg && !write_reg) begin
				rdata_reg <= read_data_i;
			end
			if (state_reg == DEV_DATA && !ack_reg && write_reg) begin
				wdata_reg <= {bus.data_high_half_m, bus.data_low_half_m}; // (RULE17)
				wvalid_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			accepted_kind_o <= '0;
			accepted_size_o <= '0;
			accepted_coherent_o <= 1'b0;
			accepted_write_through_o <= 1'b0;
			accepted_no_cache_o <= 1'b0;
		end else if (en_i && state_reg == DEV_IDLE && start_seen && !snoop_reg) begin
			accepted_kind_o <= bus.transfer_kind; // (RULE12)
			accepted_size_o <= bus.beat_size; // (RULE11)
			accepted_coherent_o <= bus.coherent_access; // (RULE13)
			accepted_write_through_o <= bus.write_through_hint; // (RULE15)
			accepted_no_cache_o <= bus.no_cache_hint;
		end
	end

	// Broadcasts are only launched while idle with no start seen; a master request raised in the same cycle can still collide with one.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			snoop_reg <= 1'b0;
		end else if (en_i) begin
			snoop_reg <= snoop_req_i && !snoop_reg && state_reg == DEV_IDLE && !start_seen; // (RULE8)
		end
	end

	// Machine check is sticky until reset; the processor must restart anyway.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mcp_reg <= 1'b0;
		end else if (en_i && fatal_error_i) begin
			mcp_reg <= 1'b1; // (RULE10)
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign bus.dev_transaction_begin = snoop_reg; // (RULE8)
	assign bus.dev_transfer_kind = KIND_SNOOP_BCAST;
	assign bus.dev_beat_size = SIZE_DWORD;
	assign bus.dev_burst_flag = 1'b0;
	assign bus.dev_coherent_access = snoop_reg & snoop_coherent_i;
	assign bus.dev_write_through_hint = snoop_reg & snoop_write_through_i;
	assign bus.dev_no_cache_hint = snoop_reg & snoop_no_cache_i;
	assign bus.dev_attr_oe = snoop_reg;
	assign bus.address_phase_done = address_phase_done_reg;
	assign bus.data_high_half_d = rdata_reg[DATA_W-1:HALF_W];
	assign bus.data_low_half_d = rdata_reg[HALF_W-1:0];
	assign bus.data_d_oe = (state_reg == DEV_DATA) && !write_reg;
	assign bus.beat_acknowledge = ack_reg;
	assign bus.bus_error_ack = err_reg;
	assign bus.fatal_error_out = mcp_reg;
	assign snoop_busy_o = snoop_reg;
	assign write_data_o = wdata_reg;
	assign write_valid_o = wvalid_reg;
	assign tenure_done_o = done_reg;
endmodule

// >>> xfer_master.sv
`timescale 1ns/100ps
module xfer_master
	import xfer_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	// Link.
	xfer_if.master bus,
	// Request side.
	input wire logic req_i,
	input wire logic req_extended_i,
	input wire logic [KIND_W-1:0] req_kind_i,
	input wire logic [SIZE_W-1:0] req_size_i,
	input wire logic req_burst_i,
	input wire logic req_coherent_i,
	input wire logic req_write_through_i,
	input wire logic req_no_cache_i,
	input wire logic req_side_claim_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	// Answer side.
	output logic busy_o,
	output logic [DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic done_o,
	output logic error_o,
	output logic snoop_seen_o,
	output logic [KIND_W-1:0] snoop_kind_o,
	output logic fatal_o
);
	mst_state_t state_reg;
	logic begin_reg;
	logic ext_reg;
	logic [KIND_W-1:0] kind_reg;
	logic [SIZE_W-1:0] size_reg;
	logic burst_reg;
	logic gbl_reg;
	logic wt_reg;
	logic ci_reg;
	logic claim_reg;
	logic [BEATS_W-1:0] beats_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic side_ack_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic rvalid_reg;
	logic done_reg;
	logic error_reg;
	logic snoop_reg;
	logic [KIND_W-1:0] snoop_kind_reg;
	logic fatal_meta_reg;
	logic fatal_reg;
	logic any_ack;

	////////////////////////////////////////////////////////////////////////////////
	assign any_ack = bus.beat_acknowledge || side_ack_reg;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= MST_IDLE;
			begin_reg <= 1'b0;
			ext_reg <= 1'b0;
			kind_reg <= '0;
			size_reg <= '0;
			burst_reg <= 1'b0;
			gbl_reg <= 1'b0;
			wt_reg <= 1'b0;
			ci_reg <= 1'b0;
			claim_reg <= 1'b0;
			beats_reg <= ZERO_BEATS;
			wdata_reg <= '0;
			done_reg <= 1'b0;
			error_reg <= 1'b0;
		end else if (en_i) begin
			begin_reg <= 1'b0;
			ext_reg <= 1'b0;
			done_reg <= 1'b0;
			error_reg <= 1'b0;
			unique case (state_reg)
				MST_IDLE: begin
					if (req_i && !bus.dev_transaction_begin) begin
						// Start and attributes become valid in the same cycle.
						begin_reg <= !req_extended_i; // (RULE9)
						ext_reg <= req_extended_i;
						kind_reg <= req_kind_i; // (RULE12)
						size_reg <= req_size_i; // (RULE11)
						burst_reg <= req_burst_i; // (RULE14)
						gbl_reg <= req_coherent_i; // (RULE13)
						wt_reg <= req_write_through_i; // (RULE15)
						ci_reg <= req_no_cache_i;
						claim_reg <= req_side_claim_i; // (RULE4)
						wdata_reg <= req_wdata_i;
						beats_reg <= req_burst_i ? BURST_BEATS : SINGLE_BEATS;
						state_reg <= MST_ADDR;
					end
				end
				MST_ADDR: begin
					if (bus.address_phase_done) begin
						state_reg <= MST_DATA; // (RULE16)
						claim_reg <= 1'b0;
					end
				end
				MST_DATA: begin
					if (bus.bus_error_ack) begin
						state_reg <= MST_IDLE; // (RULE5)
						error_reg <= 1'b1;
						done_reg <= 1'b1;
					end else if (any_ack) begin
						beats_reg <= beats_reg - ONE_BEAT;
						if (beats_reg == ONE_BEAT) begin
							state_reg <= MST_IDLE; // (RULE2)
							done_reg <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// The claiming side slave is modelled here as answering one beat every other cycle.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			side_ack_reg <= 1'b0;
		end else if (en_i) begin
			side_ack_reg <= (state_reg == MST_DATA) && req_side_claim_i && !side_ack_reg &&
				!(side_ack_reg && beats_reg == ONE_BEAT); // (RULE3)
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else if (en_i) begin
			rvalid_reg <= 1'b0;
			if (state_reg == MST_DATA && bus.beat_acknowledge && bus.data_d_oe) begin
				rdata_reg <= {bus.data_high_half_d, bus.data_low_half_d}; // (RULE17)
				rvalid_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			snoop_reg <= 1'b0;
			snoop_kind_reg <= '0;
		end else if (en_i) begin
			snoop_reg <= bus.dev_transaction_begin; // (RULE8)
			if (bus.dev_transaction_begin) begin
				snoop_kind_reg <= bus.dev_transfer_kind;
			end
		end
	end

	// Machine check is an asynchronous exception source, so it is synchronised.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fatal_meta_reg <= 1'b0;
			fatal_reg <= 1'b0;
		end else if (en_i) begin
			fatal_meta_reg <= bus.fatal_error_out;
			fatal_reg <= fatal_meta_reg; // (RULE10)
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign bus.transaction_begin = begin_reg;
	assign bus.extended_start_request = ext_reg;
	assign bus.transfer_kind = kind_reg;
	assign bus.beat_size = size_reg;
	assign bus.burst_flag = burst_reg && state_reg != MST_IDLE;
	assign bus.coherent_access = gbl_reg;
	assign bus.write_through_hint = wt_reg;
	assign bus.no_cache_hint = ci_reg;
	assign bus.side_slave_claim = claim_reg && state_reg == MST_ADDR;
	assign bus.data_high_half_m = wdata_reg[DATA_W-1:HALF_W];
	assign bus.data_low_half_m = wdata_reg[HALF_W-1:0];
	assign bus.side_beat_acknowledge = side_ack_reg;
	assign bus.address_retry = 1'b0;
	assign busy_o = state_reg != MST_IDLE;
	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign done_o = done_reg;
	assign error_o = error_reg;
	assign snoop_seen_o = snoop_reg;
	assign snoop_kind_o = snoop_kind_reg;
	assign fatal_o = fatal_reg;
endmodule

// >>> xfer_assertions.sv
`timescale 1ns/100ps
module xfer_assertions
	import xfer_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Watched link signals.
	input wire logic transaction_begin,
	input wire logic extended_start_request,
	input wire logic burst_flag,
	input wire logic side_slave_claim,
	input wire logic dev_transaction_begin,
	input wire logic [KIND_W-1:0] dev_transfer_kind,
	input wire logic dev_attr_oe,
	input wire logic address_phase_done,
	input wire logic beat_acknowledge,
	input wire logic bus_error_ack,
	input wire logic fatal_error_out
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////////
	a_phase_done_next: assert property (
		(transaction_begin || extended_start_request) |=> address_phase_done)
		else $error("address phase not acknowledged one cycle after start");
	a_first_answer: assert property (
		(transaction_begin && !side_slave_claim) ##1 !side_slave_claim
		|-> ##1 (beat_acknowledge || bus_error_ack))
		else $error("no beat or error answer two cycles after start");
	a_ack_spaced: assert property (
		beat_acknowledge |=> !beat_acknowledge)
		else $error("beat acknowledge longer than one cycle");
	a_no_overlap: assert property (
		bus_error_ack |-> !beat_acknowledge)
		else $error("error and beat acknowledge together");
	a_error_ends_tenure: assert property (
		bus_error_ack |=> (!beat_acknowledge && !bus_error_ack) [*3])
		else $error("acknowledge after error termination");
	a_claim_silent: assert property (
		(transaction_begin && side_slave_claim) |=> !beat_acknowledge [*4])
		else $error("device acknowledged a claimed transaction");
	a_burst_four: assert property (
		(transaction_begin && burst_flag && !side_slave_claim) ##1 !side_slave_claim
		##1 beat_acknowledge
		|-> ##2 beat_acknowledge ##2 beat_acknowledge ##2 beat_acknowledge
		##1 !beat_acknowledge [*3])
		else $error("burst did not end after four beats");
	a_bcast_only: assert property (
		dev_transaction_begin |-> (dev_transfer_kind == KIND_SNOOP_BCAST) && dev_attr_oe)
		else $error("device started a non-broadcast transaction");
	a_bcast_yield: assert property (
		dev_transaction_begin |-> !transaction_begin && !extended_start_request)
		else $error("broadcast collided with a master start");
	a_fatal_sticky: assert property (
		fatal_error_out |=> fatal_error_out)
		else $error("machine check dropped before reset");
endmodule

// >>> tb_processor_bus_transfer_control.sv
`timescale 1ns/100ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_processor_bus_transfer_control;
	import xfer_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic en_i = 1'b1;
	logic error_ack_enable_i = 1'b1, fatal_error_i = 1'b0, snoop_req_i = 1'b0;
	logic snoop_coherent_i = 1'b1, snoop_write_through_i = 1'b1, snoop_no_cache_i = 1'b0;
	logic [DATA_W-1:0] read_data_i = 64'h0123_4567_89ab_cdef;
	logic req_i = 1'b0, req_extended_i = 1'b0, req_burst_i = 1'b0, req_coherent_i = 1'b0;
	logic req_write_through_i = 1'b0, req_no_cache_i = 1'b0, req_side_claim_i = 1'b0;
	logic [KIND_W-1:0] req_kind_i = KIND_READ;
	logic [SIZE_W-1:0] req_size_i = SIZE_DWORD;
	logic [DATA_W-1:0] req_wdata_i = 64'h0;
	logic snoop_busy_o, write_valid_o, acc_coh, acc_wt, acc_ci, tenure_done_o;
	logic [DATA_W-1:0] write_data_o, rdata_o;
	logic [KIND_W-1:0] acc_kind, snoop_kind_o;
	logic [SIZE_W-1:0] acc_size;
	logic busy_o, rvalid_o, done_o, error_o, snoop_seen_o, fatal_o, err;
	int num_errors = 0, check_count = 0;
	int ack_cnt, err_cnt, wv_cnt, td_cnt, bc_cnt, rv_cnt, sb_cnt;
	logic [HALF_W-1:0] hi_d, lo_d, hi_m, lo_m;
	logic [2:0] bc_attr;

	always #5 clk_i = ~clk_i;

	xfer_if xfer_if_i ();
	// One enable drives both ends so that a freeze stops the whole link.
	xfer_device xfer_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .bus(xfer_if_i),
		.error_ack_enable_i(error_ack_enable_i), .fatal_error_i(fatal_error_i),
		.snoop_req_i(snoop_req_i), .snoop_coherent_i(snoop_coherent_i),
		.snoop_write_through_i(snoop_write_through_i), .snoop_no_cache_i(snoop_no_cache_i),
		.read_data_i(read_data_i), .snoop_busy_o(snoop_busy_o), .write_data_o(write_data_o),
		.write_valid_o(write_valid_o), .accepted_kind_o(acc_kind), .accepted_size_o(acc_size),
		.accepted_coherent_o(acc_coh), .accepted_write_through_o(acc_wt),
		.accepted_no_cache_o(acc_ci), .tenure_done_o(tenure_done_o));
	xfer_master xfer_master_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .bus(xfer_if_i),
		.req_i(req_i), .req_extended_i(req_extended_i), .req_kind_i(req_kind_i),
		.req_size_i(req_size_i), .req_burst_i(req_burst_i), .req_coherent_i(req_coherent_i),
		.req_write_through_i(req_write_through_i), .req_no_cache_i(req_no_cache_i),
		.req_side_claim_i(req_side_claim_i), .req_wdata_i(req_wdata_i), .busy_o(busy_o),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .done_o(done_o), .error_o(error_o),
		.snoop_seen_o(snoop_seen_o), .snoop_kind_o(snoop_kind_o), .fatal_o(fatal_o));
	xfer_assertions xfer_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.transaction_begin(xfer_if_i.transaction_begin),
		.extended_start_request(xfer_if_i.extended_start_request),
		.burst_flag(xfer_if_i.burst_flag), .side_slave_claim(xfer_if_i.side_slave_claim),
		.dev_transaction_begin(xfer_if_i.dev_transaction_begin),
		.dev_transfer_kind(xfer_if_i.dev_transfer_kind), .dev_attr_oe(xfer_if_i.dev_attr_oe),
		.address_phase_done(xfer_if_i.address_phase_done),
		.beat_acknowledge(xfer_if_i.beat_acknowledge), .bus_error_ack(xfer_if_i.bus_error_ack),
		.fatal_error_out(xfer_if_i.fatal_error_out));

	////////////////////////////////////////////////////////////////////////////////
	// Wire watcher: counts terminations and keeps the data seen on each beat.
	always @(posedge clk_i) begin
		if (xfer_if_i.beat_acknowledge === 1'b1) begin
			ack_cnt++;
			{hi_d, lo_d, hi_m, lo_m} = {xfer_if_i.data_high_half_d, xfer_if_i.data_low_half_d,
				xfer_if_i.data_high_half_m, xfer_if_i.data_low_half_m};
		end
		if (xfer_if_i.bus_error_ack === 1'b1) err_cnt++;
		if (write_valid_o === 1'b1) wv_cnt++;
		if (rvalid_o === 1'b1) rv_cnt++;
		if (snoop_busy_o === 1'b1) sb_cnt++;
		if (tenure_done_o === 1'b1) td_cnt++;
		if (xfer_if_i.dev_transaction_begin === 1'b1) begin
			bc_cnt++;
			bc_attr = {xfer_if_i.dev_coherent_access, xfer_if_i.dev_write_through_hint,
				xfer_if_i.dev_no_cache_hint};
		end
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One master request, held for one edge, then a bounded wait for its completion.
	task automatic run(input logic [KIND_W-1:0] kind, input logic burst, ext, claim,
		input logic [DATA_W-1:0] wd);
		int n;
		{ack_cnt, err_cnt, wv_cnt, td_cnt, rv_cnt} = '0;
		{req_kind_i, req_burst_i, req_extended_i, req_side_claim_i, req_wdata_i} =
			{kind, burst, ext, claim, wd};
		req_i = 1'b1;
		@(posedge clk_i);
		#1 req_i = 1'b0;
		req_extended_i = 1'b0;
		for (n = 0; n < 40 && done_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 40) begin
			num_errors++;
			conclude();
		end
		err = error_o;
		req_side_claim_i = 1'b0;
		// One more edge so that the watcher sees the pulses of the closing cycle.
		@(posedge clk_i);
		#1;
	endtask

	task automatic t_read_single();
		{req_coherent_i, req_write_through_i, req_no_cache_i} = 3'b101;
		run(KIND_READ, 1'b0, 1'b0, 1'b0, 64'h0);
		`CHECK(err, 1'b0)
		`CHECK(ack_cnt, 1)
		`CHECK(td_cnt, 1)
		`CHECK({hi_d, lo_d}, read_data_i)
		`CHECK(rdata_o, read_data_i)
		`CHECK(rv_cnt, 1)
		`CHECK({acc_kind, acc_size}, {KIND_READ, SIZE_DWORD})
		`CHECK({acc_coh, acc_wt, acc_ci}, 3'b101)
	endtask

	task automatic t_write_burst();
		{req_coherent_i, req_write_through_i, req_no_cache_i} = 3'b010;
		run(KIND_WRITE, 1'b1, 1'b0, 1'b0, 64'hfeed_0001_cafe_0002);
		`CHECK(ack_cnt, 4)
		`CHECK(td_cnt, 1)
		`CHECK({hi_m, lo_m}, 64'hfeed_0001_cafe_0002)
		`CHECK(write_data_o, 64'hfeed_0001_cafe_0002)
		`CHECK(wv_cnt, 4)
		`CHECK(rv_cnt, 0)
		`CHECK({acc_kind, acc_coh, acc_wt, acc_ci}, {KIND_WRITE, 3'b010})
	endtask

	task automatic t_error_kinds();
		logic [KIND_W-1:0] kinds [3];
		kinds = '{KIND_GFX_READ, KIND_GFX_WRITE, 5'h14};
		foreach (kinds[i]) begin
			run(kinds[i], 1'b0, 1'b0, 1'b0, 64'h0);
			`CHECK({err, err_cnt, ack_cnt}, {1'b1, 32'd1, 32'd0})
		end
		// With error answers disabled the same kind completes normally.
		error_ack_enable_i = 1'b0;
		run(KIND_GFX_READ, 1'b0, 1'b0, 1'b0, 64'h0);
		`CHECK({err, err_cnt, ack_cnt}, {1'b0, 32'd0, 32'd1})
		error_ack_enable_i = 1'b1;
	endtask

	task automatic t_extended();
		run(KIND_READ, 1'b0, 1'b1, 1'b0, 64'h0);
		`CHECK({err, err_cnt, ack_cnt, td_cnt}, {1'b1, 32'd1, 32'd0, 32'd1})
	endtask

	task automatic t_claim();
		run(KIND_READ, 1'b0, 1'b0, 1'b1, 64'h0);
		`CHECK({err, ack_cnt, td_cnt}, {1'b0, 32'd0, 32'd1})
	endtask

	task automatic t_snoop();
		int n;
		bc_cnt = 0;
		sb_cnt = 0;
		snoop_req_i = 1'b1;
		@(posedge clk_i);
		#1 snoop_req_i = 1'b0;
		for (n = 0; n < 20 && snoop_seen_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 20) begin
			num_errors++;
			conclude();
		end
		`CHECK(snoop_kind_o, KIND_SNOOP_BCAST)
		`CHECK(sb_cnt, 1)
		`CHECK(bc_cnt, 1)
		`CHECK(bc_attr, 3'b110)
	endtask

	task automatic t_fatal();
		int n;
		// A frozen link must not take the error until the enable returns.
		en_i = 1'b0;
		fatal_error_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1 `CHECK({busy_o, xfer_if_i.fatal_error_out}, 2'b00)
		en_i = 1'b1;
		for (n = 0; n < 10 && fatal_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 10) begin
			num_errors++;
			conclude();
		end
		fatal_error_i = 1'b0;
		repeat (5) @(posedge clk_i);
		#1;
		`CHECK({fatal_o, xfer_if_i.fatal_error_out}, 2'b11)
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		t_read_single();
		t_write_burst();
		t_error_kinds();
		t_extended();
		t_claim();
		t_snoop();
		t_fatal();
		conclude();
	end
endmodule
